// [cox_pkg.sv]
// Constants, register map and opcode encodings of the opcode execution block
package cox_pkg;
   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ACC_W = 24;
   localparam int DISP_W = 8;
   localparam int ADR_W = 8;
   localparam int OP_W = 4;
   localparam int CNT_W = 3;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADR_ACC_X = 8'h00;
   localparam logic [7:0] ADR_ACC_Y = 8'h04;
   localparam logic [7:0] ADR_ACC_Z = 8'h08;
   localparam logic [7:0] ADR_ACC_R = 8'h0C;
   localparam logic [7:0] ADR_CMD = 8'h10;
   localparam logic [7:0] ADR_CONST = 8'h14;
   localparam logic [7:0] ADR_STATUS = 8'h18;
   localparam logic [7:0] ADR_DISP61 = 8'h1C;
   localparam logic [7:0] ADR_DISP62 = 8'h20;

   // ---------------------------------------------------------------
   // Command register fields
   // ---------------------------------------------------------------
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_P1_LSB = 4;
   localparam int CMD_P2_LSB = 6;
   localparam int CMD_CONST_BIT = 8;

   // ---------------------------------------------------------------
   // Status register fields
   // ---------------------------------------------------------------
   localparam int ST_C = 0;
   localparam int ST_O = 1;
   localparam int ST_S = 2;
   localparam int ST_Z = 3;
   localparam int ST_BUSY = 4;
   localparam int ST_LEN_LSB = 8;

   // ---------------------------------------------------------------
   // Opcodes
   // ---------------------------------------------------------------
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_BLANK = 4'h1;
   localparam logic [3:0] OP_WDT = 4'h2;
   localparam logic [3:0] OP_CMP = 4'h3;
   localparam logic [3:0] OP_NEG = 4'h4;
   localparam logic [3:0] OP_DEC = 4'h5;
   localparam logic [3:0] OP_CLRCO = 4'h6;

   // ---------------------------------------------------------------
   // Instruction lengths in bytes and cycles
   // ---------------------------------------------------------------
   localparam logic [2:0] LEN_ONE = 3'h1;
   localparam logic [2:0] LEN_TWO = 3'h2;
   localparam logic [2:0] LEN_FOUR = 3'h4;

   // ---------------------------------------------------------------
   // Reset values and default ROM target
   // ---------------------------------------------------------------
   localparam logic [23:0] ACC_RST = 24'h000000;
   localparam logic [7:0] DISP_RST = 8'h00;
   localparam logic [15:0] BLANK_ROM_ADR = 16'h0F00;
endpackage : cox_pkg

// [cox_alu_if.sv]
// Carrier between the execution core and its arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface cox_alu_if;
   logic [3:0] op;
   logic [cox_pkg::ACC_W-1:0] a;
   logic [cox_pkg::ACC_W-1:0] b;
   logic [cox_pkg::ACC_W-1:0] res;
   logic c;
   logic o;
   logic s;
   logic z;
   modport core (output op, output a, output b, input res, input c, input o, input s, input z);
   modport alu (input op, input a, input b, output res, output c, output o, output s, output z);
endinterface : cox_alu_if
`default_nettype wire

// [cox_alu.sv]
// Arithmetic unit for compare, negate and decrement
`timescale 1ns/1ns
`default_nettype none
module cox_alu (
   cox_alu_if.alu u
);
   logic [cox_pkg::ACC_W:0] wide;

   always_comb begin
      wide = {1'b0, u.b} - {1'b0, u.a};
      u.res = u.a;
      u.c = 1'b0;
      u.o = 1'b0;
      case (u.op)
         cox_pkg::OP_CMP: begin
            // Borrow out of b - a is the carry; operands are not written
            wide = {1'b0, u.b} - {1'b0, u.a};                        // [RQ6]
            u.res = wide[cox_pkg::ACC_W-1:0];
            u.c = wide[cox_pkg::ACC_W];                                 // [RQ10]
            u.o = (u.b[23] ^ u.a[23]) & (u.res[23] ^ u.b[23]);          // [RQ10]
         end
         cox_pkg::OP_NEG: begin
            u.res = ~u.a + 24'h000001;                                  // [RQ8]
         end
         cox_pkg::OP_DEC: begin
            wide = {1'b0, u.a} - 25'h0000001;                           // [RQ9]
            u.res = wide[cox_pkg::ACC_W-1:0];
            u.c = wide[cox_pkg::ACC_W];
            u.o = u.a[23] & ~u.res[23];
         end
         default: begin
            u.res = u.a;
         end
      endcase
      u.s = u.res[23];                                                  // [RQ11]
      u.z = (u.res == 24'h000000);                                      // [RQ11]
   end
endmodule : cox_alu
`default_nettype wire

// [cox_top.sv]
// Execution core for six processor opcodes with a Wishbone register port
// Functional notes
// [RQ1] Blank-display zeroes display registers 61 and 62 and is one byte long.
// [RQ2] Blank-display runs as a call into a ROM subroutine rather than a dedicated operation.
// [RQ3] Software follows blank-display with a display update so the segments go dark.
// [RQ4] Watchdog-clear restarts the watchdog, is two bytes long and keeps the flags.
// [RQ5] Software issues watchdog-clear at the end of each run just before stop.
// [RQ6] Compare computes second minus first operand, sets C O S Z and writes no register.
// [RQ7] Compare takes an accumulator and an accumulator (1 byte 1 cycle) or a constant (4 and 4).
// [RQ8] Negate writes the two's complement back, updates S and Z only, 2 bytes 2 cycles.
// [RQ9] Decrement subtracts one, writes back, updates C O S Z, 1 byte 1 cycle.
// [RQ10] C is carry and O is overflow, and one instruction clears both together.
// [RQ11] S is the result's top bit and Z is set exactly when all 24 result bits are zero.
`timescale 1ns/1ns
`default_nettype none
module cox_top #(
   parameter logic [15:0] BLANK_ROM_ADR = cox_pkg::BLANK_ROM_ADR
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [cox_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wdt_clear_o,
   output logic rom_call_o,
   output logic [15:0] rom_call_adr_o
);
   typedef enum logic [0:0] {ST_IDLE, ST_EXEC} cox_state_t;

   // ---------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------
   function automatic logic [2:0] cycles_of(input logic [3:0] op, input logic use_const);
      case (op)
         cox_pkg::OP_CMP: cycles_of = use_const ? cox_pkg::LEN_FOUR : cox_pkg::LEN_ONE; // [RQ7]
         cox_pkg::OP_NEG: cycles_of = cox_pkg::LEN_TWO;                                 // [RQ8]
         default: cycles_of = cox_pkg::LEN_ONE;                                         // [RQ9]
      endcase
   endfunction : cycles_of

   function automatic logic [2:0] bytes_of(input logic [3:0] op, input logic use_const);
      case (op)
         cox_pkg::OP_CMP: bytes_of = use_const ? cox_pkg::LEN_FOUR : cox_pkg::LEN_ONE;  // [RQ7]
         cox_pkg::OP_NEG: bytes_of = cox_pkg::LEN_TWO;                                  // [RQ8]
         cox_pkg::OP_WDT: bytes_of = cox_pkg::LEN_TWO;                                  // [RQ4]
         default: bytes_of = cox_pkg::LEN_ONE;                                          // [RQ1]
      endcase
   endfunction : bytes_of

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   cox_state_t state_r, state_nxt;
   logic [cox_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [3:0] op_r, op_nxt;
   logic [1:0] p1_r, p1_nxt;
   logic [1:0] p2_r, p2_nxt;
   logic konst_r, konst_nxt;
   logic [cox_pkg::ACC_W-1:0] acc_r [4];
   logic [cox_pkg::ACC_W-1:0] acc_nxt [4];
   logic [cox_pkg::ACC_W-1:0] const_r, const_nxt;
   logic [cox_pkg::DISP_W-1:0] disp61_r, disp61_nxt;
   logic [cox_pkg::DISP_W-1:0] disp62_r, disp62_nxt;
   logic fc_r, fc_nxt, fo_r, fo_nxt, fs_r, fs_nxt, fz_r, fz_nxt;
   logic [2:0] len_r, len_nxt;
   logic wdt_r, wdt_nxt;
   logic call_r, call_nxt;
   logic req;
   logic wr;

   cox_alu_if alu_bus ();

   cox_alu u_alu (
      .u (alu_bus)
   );

   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr = req & wb_we_i;
   assign alu_bus.op = op_r;
   assign alu_bus.a = acc_r[p1_r];
   assign alu_bus.b = konst_r ? const_r : acc_r[p2_r];

   // ---------------------------------------------------------------
   // Bus slave: ack one cycle after the request, zero for unmapped reads
   // ---------------------------------------------------------------
   always_comb begin
      ack_nxt = req;
      dat_nxt = dat_r;
      if (req) begin
         dat_nxt = 32'h00000000;
         case (wb_adr_i)
            cox_pkg::ADR_ACC_X: dat_nxt[23:0] = acc_r[0];
            cox_pkg::ADR_ACC_Y: dat_nxt[23:0] = acc_r[1];
            cox_pkg::ADR_ACC_Z: dat_nxt[23:0] = acc_r[2];
            cox_pkg::ADR_ACC_R: dat_nxt[23:0] = acc_r[3];
            cox_pkg::ADR_CMD: dat_nxt[8:0] = {konst_r, p2_r, p1_r, op_r};
            cox_pkg::ADR_CONST: dat_nxt[23:0] = const_r;
            cox_pkg::ADR_STATUS: begin
               dat_nxt[cox_pkg::ST_C] = fc_r;
               dat_nxt[cox_pkg::ST_O] = fo_r;
               dat_nxt[cox_pkg::ST_S] = fs_r;
               dat_nxt[cox_pkg::ST_Z] = fz_r;
               dat_nxt[cox_pkg::ST_BUSY] = (state_r == ST_EXEC);
               dat_nxt[cox_pkg::ST_LEN_LSB +: 3] = len_r;
            end
            cox_pkg::ADR_DISP61: dat_nxt[7:0] = disp61_r;
            cox_pkg::ADR_DISP62: dat_nxt[7:0] = disp62_r;
            default: dat_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Execution core
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      op_nxt = op_r;
      p1_nxt = p1_r;
      p2_nxt = p2_r;
      konst_nxt = konst_r;
      acc_nxt = acc_r;
      const_nxt = const_r;
      disp61_nxt = disp61_r;
      disp62_nxt = disp62_r;
      fc_nxt = fc_r;
      fo_nxt = fo_r;
      fs_nxt = fs_r;
      fz_nxt = fz_r;
      len_nxt = len_r;
      wdt_nxt = 1'b0;
      call_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            // Registers are writable only while no instruction runs
            if (wr && wb_sel_i[0]) begin
               case (wb_adr_i)
                  cox_pkg::ADR_ACC_X: acc_nxt[0] = wb_dat_i[23:0];
                  cox_pkg::ADR_ACC_Y: acc_nxt[1] = wb_dat_i[23:0];
                  cox_pkg::ADR_ACC_Z: acc_nxt[2] = wb_dat_i[23:0];
                  cox_pkg::ADR_ACC_R: acc_nxt[3] = wb_dat_i[23:0];
                  cox_pkg::ADR_CONST: const_nxt = wb_dat_i[23:0];
                  cox_pkg::ADR_DISP61: disp61_nxt = wb_dat_i[7:0];
                  cox_pkg::ADR_DISP62: disp62_nxt = wb_dat_i[7:0];
                  cox_pkg::ADR_CMD: begin
                     op_nxt = wb_dat_i[cox_pkg::CMD_OP_LSB +: 4];
                     p1_nxt = wb_dat_i[cox_pkg::CMD_P1_LSB +: 2];
                     p2_nxt = wb_dat_i[cox_pkg::CMD_P2_LSB +: 2];
                     konst_nxt = wb_dat_i[cox_pkg::CMD_CONST_BIT];
                     cnt_nxt = cycles_of(op_nxt, konst_nxt) - 3'h1;
                     len_nxt = bytes_of(op_nxt, konst_nxt);
                     state_nxt = ST_EXEC;
                  end
                  default: begin
                     state_nxt = ST_IDLE;
                  end
               endcase
            end
         end
         ST_EXEC: begin
            if (cnt_r != 3'h0) begin
               cnt_nxt = cnt_r - 3'h1;
            end else begin
               state_nxt = ST_IDLE;
               case (op_r)
                  cox_pkg::OP_BLANK: begin
                     disp61_nxt = cox_pkg::DISP_RST;                  // [RQ1]
                     disp62_nxt = cox_pkg::DISP_RST;                  // [RQ1]
                     call_nxt = 1'b1;                                 // [RQ2]
                  end
                  cox_pkg::OP_WDT: begin
                     wdt_nxt = 1'b1;                                  // [RQ4]
                  end
                  cox_pkg::OP_CMP: begin
                     fc_nxt = alu_bus.c;                              // [RQ6]
                     fo_nxt = alu_bus.o;                              // [RQ6]
                     fs_nxt = alu_bus.s;                              // [RQ11]
                     fz_nxt = alu_bus.z;                              // [RQ11]
                  end
                  cox_pkg::OP_NEG: begin
                     acc_nxt[p1_r] = alu_bus.res;                     // [RQ8]
                     fs_nxt = alu_bus.s;                              // [RQ8]
                     fz_nxt = alu_bus.z;                              // [RQ8]
                  end
                  cox_pkg::OP_DEC: begin
                     acc_nxt[p1_r] = alu_bus.res;                     // [RQ9]
                     fc_nxt = alu_bus.c;                              // [RQ9]
                     fo_nxt = alu_bus.o;                              // [RQ9]
                     fs_nxt = alu_bus.s;                              // [RQ9]
                     fz_nxt = alu_bus.z;                              // [RQ9]
                  end
                  cox_pkg::OP_CLRCO: begin
                     fc_nxt = 1'b0;                                   // [RQ10]
                     fo_nxt = 1'b0;                                   // [RQ10]
                  end
                  default: begin
                     state_nxt = ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         cnt_r <= 3'h0;
         op_r <= cox_pkg::OP_NOP;
         p1_r <= 2'h0;
         p2_r <= 2'h0;
         konst_r <= 1'b0;
         acc_r <= '{default: cox_pkg::ACC_RST};
         const_r <= cox_pkg::ACC_RST;
         disp61_r <= cox_pkg::DISP_RST;
         disp62_r <= cox_pkg::DISP_RST;
         fc_r <= 1'b0;
         fo_r <= 1'b0;
         fs_r <= 1'b0;
         fz_r <= 1'b0;
         len_r <= 3'h0;
         wdt_r <= 1'b0;
         call_r <= 1'b0;
         rom_call_adr_o <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         op_r <= op_nxt;
         p1_r <= p1_nxt;
         p2_r <= p2_nxt;
         konst_r <= konst_nxt;
         acc_r <= acc_nxt;
         const_r <= const_nxt;
         disp61_r <= disp61_nxt;
         disp62_r <= disp62_nxt;
         fc_r <= fc_nxt;
         fo_r <= fo_nxt;
         fs_r <= fs_nxt;
         fz_r <= fz_nxt;
         len_r <= len_nxt;
         wdt_r <= wdt_nxt;
         call_r <= call_nxt;
         rom_call_adr_o <= BLANK_ROM_ADR;                             // [RQ2]
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign wdt_clear_o = wdt_r;
   assign rom_call_o = call_r;
endmodule : cox_top
`default_nettype wire

// [cox_checker.sv]
// Port checker for the opcode execution block
`timescale 1ns/1ns
`default_nettype none
module cox_checker #(
   parameter logic [15:0] BLANK_ROM_ADR = cox_pkg::BLANK_ROM_ADR
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [cox_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wdt_clear_o,
   input wire logic rom_call_o,
   input wire logic [15:0] rom_call_adr_o
);
   logic req;
   logic rd_req;
   logic cmd_wr;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd_req = req && !wb_we_i;
   assign cmd_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == cox_pkg::ADR_CMD;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (req |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   AST_UNMAPPED_ZERO: assert property (rd_req && wb_adr_i > cox_pkg::ADR_DISP62
      |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   AST_DISP_WIDTH: assert property (
      rd_req && (wb_adr_i == cox_pkg::ADR_DISP61 || wb_adr_i == cox_pkg::ADR_DISP62)
      |=> wb_dat_o[31:8] == 24'h0) else $error("display register wider than a byte");
   AST_STATUS_FIELDS: assert property (
      rd_req && wb_adr_i == cox_pkg::ADR_STATUS |=> wb_dat_o[31:11] == 21'h0
      && wb_dat_o[7:5] == 3'h0 && wb_dat_o[10:8] inside {3'h0, 3'h1, 3'h2, 3'h4})
      else $error("status fields out of range");
   AST_WDT_CAUSE: assert property (
      wdt_clear_o |-> $past(cmd_wr && wb_dat_i[3:0] == cox_pkg::OP_WDT, 2))
      else $error("watchdog restart without its command");
   AST_ROM_CAUSE: assert property (
      rom_call_o |-> $past(cmd_wr && wb_dat_i[3:0] == cox_pkg::OP_BLANK, 2)
      && rom_call_adr_o == BLANK_ROM_ADR) else $error("bad subroutine call");
   AST_PULSE_ONE: assert property (
      wdt_clear_o || rom_call_o |=> !wdt_clear_o && !rom_call_o)
      else $error("pulse longer than one cycle");
endmodule : cox_checker
bind cox_top cox_checker #(.BLANK_ROM_ADR(BLANK_ROM_ADR)) i_cox_checker (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wdt_clear_o(wdt_clear_o),
   .rom_call_o(rom_call_o), .rom_call_adr_o(rom_call_adr_o));
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the opcode execution block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam logic [15:0] ROM_TGT = 16'h1234;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic wdt_clear_o;
   logic rom_call_o;
   logic [15:0] rom_call_adr_o;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int wdt_cnt = 0;
   int rom_cnt = 0;
   logic [23:0] acc [4];
   logic [23:0] cst;
   logic [3:0] fl = 4'h0;
   logic [31:0] rd;

   always #25 clk_i = ~clk_i;

   cox_top #(.BLANK_ROM_ADR(ROM_TGT)) i_cox_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wdt_clear_o(wdt_clear_o),
      .rom_call_o(rom_call_o), .rom_call_adr_o(rom_call_adr_o));

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // ---------------------------------------------------------------
   // Classic Wishbone single cycle
   // ---------------------------------------------------------------
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      if (n >= 20) begin
         errors++;
         $display("wrong value at %0t: no acknowledge", $time);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : xfer

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, 4'hF);
      check(rd, exp);
   endtask : rdchk

   task automatic setacc(input int i, input logic [23:0] v);
      xfer(1'b1, 8'(i * 4), {8'hFF, v}, 4'hF);
      acc[i] = v;
   endtask : setacc

   // Flags {Z, S, O, C} of b minus a
   function automatic logic [3:0] sub_flags(input logic [23:0] a, input logic [23:0] b);
      logic [24:0] d;
      d = {1'b0, b} - {1'b0, a};
      return {d[23:0] == 24'h0, d[23], (a[23] != b[23]) && (d[23] != b[23]), d[24]};
   endfunction : sub_flags

   // ---------------------------------------------------------------
   // Issue one instruction, wait for it, compare flags and registers
   // ---------------------------------------------------------------
   task automatic run(input logic [3:0] op, input logic [1:0] p1, input logic [1:0] p2,
                      input logic k, input logic [2:0] len, input logic poke);
      logic [23:0] old;
      int n;
      old = acc[p1];
      n = 0;
      case (op)
         cox_pkg::OP_CMP: fl = sub_flags(old, k ? cst : acc[p2]);
         cox_pkg::OP_NEG: begin
            acc[p1] = ~old + 24'h1;
            fl[3:2] = {acc[p1] == 24'h0, acc[p1][23]};
         end
         cox_pkg::OP_DEC: begin
            acc[p1] = old - 24'h1;
            fl = sub_flags(24'h1, old);
         end
         cox_pkg::OP_CLRCO: fl[1:0] = 2'h0;
         default: ;
      endcase
      xfer(1'b1, cox_pkg::ADR_CMD, {23'h0, k, p2, p1, op}, 4'hF);
      if (poke) xfer(1'b1, cox_pkg::ADR_ACC_X, 32'h00ABCDEF, 4'hF);
      do begin
         xfer(1'b0, cox_pkg::ADR_STATUS, 32'h0, 4'hF);
         n++;
      end while (rd[cox_pkg::ST_BUSY] !== 1'b0 && n < 10);
      // Every instruction here ends before the first status read is taken
      check(32'(n), 32'h1);
      check(rd, {21'h0, len, 4'h0, fl});
      for (int i = 0; i < 4; i++) rdchk(8'(i * 4), {8'h0, acc[i]});
   endtask : run

   always @(posedge clk_i) begin
      cycles++;
      if (wdt_clear_o === 1'b1) wdt_cnt++;
      if (rom_call_o === 1'b1) begin
         rom_cnt++;
         check({16'h0, rom_call_adr_o}, {16'h0, ROM_TGT});
      end
      if (cycles == 20000) begin
         errors++;
         $display("wrong value at %0t: run did not finish", $time);
         stop_test();
      end
   end

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 10; i++) rdchk(8'(i * 4), 32'h0);
      xfer(1'b1, 8'h24, 32'hFFFFFFFF, 4'hF);
      rdchk(8'h24, 32'h0);
      setacc(0, 24'h000005);
      setacc(1, 24'h000003);
      setacc(2, 24'h000001);
      setacc(3, 24'h800000);
      run(cox_pkg::OP_CMP, 2'h0, 2'h1, 1'b0, cox_pkg::LEN_ONE, 1'b0);
      run(cox_pkg::OP_CMP, 2'h2, 2'h3, 1'b0, cox_pkg::LEN_ONE, 1'b0);
      run(cox_pkg::OP_CMP, 2'h1, 2'h1, 1'b0, cox_pkg::LEN_ONE, 1'b0);
      cst = 24'h7FFFFF;
      xfer(1'b1, cox_pkg::ADR_CONST, {8'hFF, cst}, 4'hF);
      setacc(3, 24'hFFFFFF);
      run(cox_pkg::OP_CMP, 2'h3, 2'h0, 1'b1, cox_pkg::LEN_FOUR, 1'b1);
      setacc(1, 24'h000000);
      setacc(2, 24'h800000);
      for (int i = 0; i < 4; i++) begin
         run(cox_pkg::OP_NEG, 2'(i), 2'h0, 1'b0, cox_pkg::LEN_TWO, 1'b0);
      end
      run(cox_pkg::OP_CLRCO, 2'h0, 2'h0, 1'b0, cox_pkg::LEN_ONE, 1'b0);
      setacc(0, 24'h123456);
      setacc(1, 24'h000001);
      setacc(2, 24'h000000);
      setacc(3, 24'h800000);
      for (int i = 0; i < 4; i++) begin
         run(cox_pkg::OP_DEC, 2'(i), 2'h0, 1'b0, cox_pkg::LEN_ONE, 1'b0);
      end
      run(cox_pkg::OP_NOP, 2'h0, 2'h0, 1'b0, cox_pkg::LEN_ONE, 1'b0);
      xfer(1'b1, cox_pkg::ADR_DISP61, 32'hFFFFFFA5, 4'hF);
      xfer(1'b1, cox_pkg::ADR_DISP62, 32'h0000005A, 4'hF);
      rdchk(cox_pkg::ADR_DISP61, 32'h000000A5);
      rdchk(cox_pkg::ADR_DISP62, 32'h0000005A);
      run(cox_pkg::OP_BLANK, 2'h0, 2'h0, 1'b0, cox_pkg::LEN_ONE, 1'b0);
      // Zeroed registers are what a following display update would transfer
      rdchk(cox_pkg::ADR_DISP61, 32'h0);
      rdchk(cox_pkg::ADR_DISP62, 32'h0);
      check(32'(rom_cnt), 32'h1);
      xfer(1'b1, cox_pkg::ADR_ACC_Y, 32'h00000077, 4'hE);
      rdchk(cox_pkg::ADR_ACC_Y, {8'h0, acc[1]});
      // Watchdog restart is the last instruction of the run
      run(cox_pkg::OP_WDT, 2'h0, 2'h0, 1'b0, cox_pkg::LEN_TWO, 1'b0);
      check(32'(wdt_cnt), 32'h1);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
